// >>> rtl/scil_pkg.sv
// Constants for the serial channel interrupt logic: offsets, bit positions, reset values.
// Assumes an 8-bit register port with word-indexed addresses.
package scil_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_STATUS_ZERO  = 4'h0;
  localparam logic [3:0] OFF_IRQ_ENABLE   = 4'h1;
  localparam logic [3:0] OFF_TX_SRC       = 4'h2;
  localparam logic [3:0] OFF_TX_SRC_EN    = 4'h3;
  localparam logic [3:0] OFF_RX_ERR       = 4'h4;
  localparam logic [3:0] OFF_RX_SRC_EN    = 4'h5;
  localparam logic [3:0] OFF_FRAME_STATUS = 4'h6;
  localparam logic [3:0] OFF_TX_THRESHOLD = 4'h7;
  localparam logic [3:0] OFF_CONTROL      = 4'h8;
  localparam logic [3:0] OFF_TIME_CONST   = 4'h9;
  localparam logic [3:0] OFF_RATE_EXP     = 4'hA;
  localparam logic [3:0] OFF_TX_DATA      = 4'hB;
  localparam logic [3:0] OFF_RX_DATA      = 4'hC;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST0_TX_EVENT = 7;
  localparam int ST0_RX_EVENT = 6;
  localparam int ST0_RX_READY = 1;
  localparam int ST0_TX_READY = 0;
  localparam int TXS_UNDERRUN = 0;
  localparam int TXS_IDLE     = 1;
  localparam int TXS_CTS      = 2;
  localparam int RXS_PARITY   = 0;
  localparam int RXS_MP       = 1;
  localparam int RXS_CRC      = 2;
  localparam int CTL_TX_EN    = 0;
  localparam int CTL_BIT_SYNC = 1;
  localparam int CTL_TX_RST   = 2;
  localparam int CTL_RX_RST   = 3;
  localparam int TX_SRC_N     = 3;
  localparam int RX_SRC_N     = 5;

  // Mask of receive sources cleared by reading the character
  localparam logic [4:0] RX_CHAR_ERR_MASK = 5'h07;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_THRESHOLD  = 8'h00;
  localparam logic [7:0] RST_TIME_CONST = 8'h01;
  localparam logic [3:0] RST_RATE_EXP   = 4'h0;

endpackage : scil_pkg

// >>> rtl/scil_top.sv
// Interrupt request logic of one multiprotocol serial channel, with its bit-rate dividers.
// Assumes the channel datapath on the same clock reports buffer fill levels and event
// pulses; only the clear-to-send pin comes from outside and is synchronised here.
//
// Overview of operation
// RULE_01 - Four request types flagged in status bits 7, 6, 1 and 0
// RULE_02 - Enable bits at same positions gate each request type
// RULE_03 - Each event source has status and enable, ANDed together
// RULE_04 - Event summary bits show enabled pending sources whatever the type enables
// RULE_05 - Transmit ready drops at fill of threshold plus one, or transmitter off
// RULE_06 - Channel reset or transmit reset command clears transmit ready
// RULE_07 - Receive ready stays until receive buffer read empty
// RULE_08 - Channel reset or receive reset command clears receive ready
// RULE_09 - Event source bits clear on writing one; zero leaves them
// RULE_10 - Idle transmitter source clears when transmit data is written
// RULE_11 - Parity, multiprocessor and CRC errors clear on reading the character
// RULE_12 - Bit-sync: last frame character read copies error status to frame status
// RULE_13 - Bit-sync: that same read resets the receive error status
// RULE_14 - Bit period is time constant times two to the rate exponent
// RULE_15 - Transmit events: underrun, idle, clear-to-send level change
// RULE_16 - Request output ORs the four status bits gated by enables
`timescale 1ns/1ps

module scil_top #(
  parameter int FILL_W = 6
) (
  input  wire logic              mclk_in,
  input  wire logic              sys_rst_in,
  input  wire logic [3:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [7:0]        reg_rdata_out,
  input  wire logic [FILL_W-1:0] tx_fill_in,
  input  wire logic [FILL_W-1:0] rx_fill_in,
  input  wire logic [7:0]        rx_data_in,
  input  wire logic              rx_last_in,
  input  wire logic              underrun_flag_in,
  input  wire logic              tx_idle_flag_in,
  input  wire logic [4:0]        rx_event_in,
  input  wire logic              cts_in,
  output logic                   tx_push_out,
  output logic      [7:0]        tx_data_out,
  output logic                   rx_pop_out,
  output logic                   tx_reset_out,
  output logic                   rx_reset_out,
  output logic                   tx_bit_tick_out,
  output logic                   rx_bit_tick_out,
  output logic                   irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  rdata;
    logic        tx_ready;
    logic        tx_cond_prev;
    logic        rx_ready;
    logic        rx_cond_prev;
    logic [7:0]  irq_enable;
    logic [2:0]  tx_src;
    logic [2:0]  tx_src_en;
    logic [4:0]  rx_err;
    logic [4:0]  rx_src_en;
    logic [4:0]  frame_status;
    logic [7:0]  threshold;
    logic        tx_en;
    logic        bit_sync;
    logic [7:0]  time_const;
    logic [3:0]  tx_exp;
    logic [3:0]  rx_exp;
    logic [23:0] tx_cnt;
    logic [23:0] rx_cnt;
    logic        tx_tick;
    logic        rx_tick;
    logic [2:0]  cts_sync;
    logic        irq;
    logic        tx_push;
    logic [7:0]  tx_data;
    logic        rx_pop;
    logic        tx_rst;
    logic        rx_rst;
  } scil_state_t;

  scil_state_t st_q;
  scil_state_t st_d;

  // Bit period in clocks; a zero time constant stands for 256
  function automatic logic [23:0] scil_period(input logic [7:0] tc, input logic [3:0] ex);
    logic [23:0] base;
    base = (tc == 8'h00) ? 24'h000100 : {16'h0000, tc};
    return base << ex;
  endfunction : scil_period

  // ----------------------------------------------------------------
  // Decode and combined status
  // ----------------------------------------------------------------
  logic       wr_tx_src;
  logic       wr_rx_err;
  logic       wr_ctl;
  logic       wr_tx_data;
  logic       rd_rx_data;
  logic       tx_rst_cmd;
  logic       rx_rst_cmd;
  logic       tx_cond;
  logic       rx_cond;
  logic       cts_change;
  logic       frame_done;
  logic [2:0] tx_set;
  logic [7:0] status_zero;

  assign wr_tx_src  = reg_wr_in && (reg_addr_in == scil_pkg::OFF_TX_SRC);
  assign wr_rx_err  = reg_wr_in && (reg_addr_in == scil_pkg::OFF_RX_ERR);
  assign wr_ctl     = reg_wr_in && (reg_addr_in == scil_pkg::OFF_CONTROL);
  assign wr_tx_data = reg_wr_in && (reg_addr_in == scil_pkg::OFF_TX_DATA);
  assign rd_rx_data = reg_rd_in && (reg_addr_in == scil_pkg::OFF_RX_DATA);
  assign tx_rst_cmd = wr_ctl && reg_wdata_in[scil_pkg::CTL_TX_RST];
  assign rx_rst_cmd = wr_ctl && reg_wdata_in[scil_pkg::CTL_RX_RST];
  // RULE_05 ready condition
  assign tx_cond    = st_q.tx_en && ({1'b0, tx_fill_in} < ({1'b0, st_q.threshold} + 9'h001));
  assign rx_cond    = (rx_fill_in != '0);
  // Only the second and third stages are compared, never the first
  assign cts_change = st_q.cts_sync[1] ^ st_q.cts_sync[2];
  assign frame_done = st_q.bit_sync && rd_rx_data && rx_last_in;
  // RULE_15 three transmit sources
  assign tx_set     = {cts_change, tx_idle_flag_in, underrun_flag_in};

  always_comb begin
    status_zero = 8'h00;
    // RULE_01 type status bits
    status_zero[scil_pkg::ST0_TX_READY] = st_q.tx_ready;
    status_zero[scil_pkg::ST0_RX_READY] = st_q.rx_ready;
    // RULE_03 per-source AND; RULE_04 independent of type enable
    status_zero[scil_pkg::ST0_TX_EVENT] = |(st_q.tx_src & st_q.tx_src_en);
    status_zero[scil_pkg::ST0_RX_EVENT] = |(st_q.rx_err & st_q.rx_src_en);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.tx_push = 1'b0;
    st_d.rx_pop  = 1'b0;
    st_d.tx_rst  = tx_rst_cmd;
    st_d.rx_rst  = rx_rst_cmd;
    st_d.cts_sync = {st_q.cts_sync[1:0], cts_in};

    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        scil_pkg::OFF_IRQ_ENABLE:   st_d.irq_enable = reg_wdata_in;
        scil_pkg::OFF_TX_SRC_EN:    st_d.tx_src_en  = reg_wdata_in[2:0];
        scil_pkg::OFF_RX_SRC_EN:    st_d.rx_src_en  = reg_wdata_in[4:0];
        scil_pkg::OFF_TX_THRESHOLD: st_d.threshold  = reg_wdata_in;
        scil_pkg::OFF_CONTROL: begin
          st_d.tx_en    = reg_wdata_in[scil_pkg::CTL_TX_EN];
          st_d.bit_sync = reg_wdata_in[scil_pkg::CTL_BIT_SYNC];
        end
        scil_pkg::OFF_TIME_CONST:   st_d.time_const = reg_wdata_in;
        scil_pkg::OFF_RATE_EXP: begin
          st_d.tx_exp = reg_wdata_in[3:0];
          st_d.rx_exp = reg_wdata_in[7:4];
        end
        scil_pkg::OFF_TX_DATA: begin
          st_d.tx_data = reg_wdata_in;
          st_d.tx_push = 1'b1;
        end
        default: ;
      endcase
    end

    // Register reads: data stands one cycle after the strobe
    st_d.rdata = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        scil_pkg::OFF_STATUS_ZERO:  st_d.rdata = status_zero;
        scil_pkg::OFF_IRQ_ENABLE:   st_d.rdata = st_q.irq_enable;
        scil_pkg::OFF_TX_SRC:       st_d.rdata = {5'h00, st_q.tx_src};
        scil_pkg::OFF_TX_SRC_EN:    st_d.rdata = {5'h00, st_q.tx_src_en};
        scil_pkg::OFF_RX_ERR:       st_d.rdata = {3'h0, st_q.rx_err};
        scil_pkg::OFF_RX_SRC_EN:    st_d.rdata = {3'h0, st_q.rx_src_en};
        scil_pkg::OFF_FRAME_STATUS: st_d.rdata = {3'h0, st_q.frame_status};
        scil_pkg::OFF_TX_THRESHOLD: st_d.rdata = st_q.threshold;
        scil_pkg::OFF_TIME_CONST:   st_d.rdata = st_q.time_const;
        scil_pkg::OFF_RATE_EXP:     st_d.rdata = {st_q.rx_exp, st_q.tx_exp};
        scil_pkg::OFF_RX_DATA: begin
          st_d.rdata  = rx_data_in;
          st_d.rx_pop = 1'b1;
        end
        default:                    st_d.rdata = 8'h00;
      endcase
    end

    // Ready requests arm on a rising condition so a reset command holds them off
    st_d.tx_cond_prev = tx_cond;
    st_d.rx_cond_prev = rx_cond;
    // RULE_05 fill or disable removes request
    if (!tx_cond) begin
      st_d.tx_ready = 1'b0;
    end else if (tx_rst_cmd) begin
      // RULE_06 reset command clear
      st_d.tx_ready = 1'b0;
    end else if (!st_q.tx_cond_prev) begin
      st_d.tx_ready = 1'b1;
    end
    // RULE_07 hold until empty
    if (!rx_cond) begin
      st_d.rx_ready = 1'b0;
    end else if (rx_rst_cmd) begin
      // RULE_08 reset command clear
      st_d.rx_ready = 1'b0;
    end else if (!st_q.rx_cond_prev) begin
      st_d.rx_ready = 1'b1;
    end

    // Source clears first; new events then win over any clear
    // RULE_09 write one to clear
    if (wr_tx_src) begin
      st_d.tx_src = st_q.tx_src & ~reg_wdata_in[2:0];
    end
    // RULE_10 data write clears idle
    if (wr_tx_data) begin
      st_d.tx_src[scil_pkg::TXS_IDLE] = 1'b0;
    end
    st_d.tx_src = st_d.tx_src | tx_set;

    // RULE_09 write one to clear
    if (wr_rx_err) begin
      st_d.rx_err = st_q.rx_err & ~reg_wdata_in[4:0];
    end
    // RULE_11 reading character clears its errors
    if (rd_rx_data) begin
      st_d.rx_err = st_d.rx_err & ~scil_pkg::RX_CHAR_ERR_MASK;
    end
    if (frame_done) begin
      // RULE_12 hand-off to frame status
      st_d.frame_status = st_q.rx_err;
      // RULE_13 error status reset
      st_d.rx_err = 5'h00;
    end
    st_d.rx_err = st_d.rx_err | rx_event_in;

    // RULE_14 bit-rate dividers
    st_d.tx_tick = (st_q.tx_cnt == 24'h000000);
    st_d.rx_tick = (st_q.rx_cnt == 24'h000000);
    st_d.tx_cnt = st_d.tx_tick ? scil_period(st_q.time_const, st_q.tx_exp) - 24'h000001
                               : st_q.tx_cnt - 24'h000001;
    st_d.rx_cnt = st_d.rx_tick ? scil_period(st_q.time_const, st_q.rx_exp) - 24'h000001
                               : st_q.rx_cnt - 24'h000001;

    // RULE_02 type enables gate; RULE_16 OR to one request
    st_d.irq = |(status_zero & st_q.irq_enable);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q            <= '0;
      // Ready requests stay idle after reset until their condition re-arms
      st_q.tx_cond_prev <= 1'b1;
      st_q.rx_cond_prev <= 1'b1;
      st_q.irq_enable <= scil_pkg::RST_IRQ_ENABLE;
      st_q.threshold  <= scil_pkg::RST_THRESHOLD;
      st_q.time_const <= scil_pkg::RST_TIME_CONST;
      st_q.tx_exp     <= scil_pkg::RST_RATE_EXP;
      st_q.rx_exp     <= scil_pkg::RST_RATE_EXP;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_out   = st_q.rdata;
  assign tx_push_out     = st_q.tx_push;
  assign tx_data_out     = st_q.tx_data;
  assign rx_pop_out      = st_q.rx_pop;
  assign tx_reset_out    = st_q.tx_rst;
  assign rx_reset_out    = st_q.rx_rst;
  assign tx_bit_tick_out = st_q.tx_tick;
  assign rx_bit_tick_out = st_q.rx_tick;
  assign irq_out         = st_q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  a_irq_gating: // RULE_16
    assert property (##1 irq_out == $past(|(status_zero & st_q.irq_enable)))
    else $error("request output does not follow gated status");

  a_summary_bits: // RULE_04
    assert property (reg_rd_in && (reg_addr_in == scil_pkg::OFF_STATUS_ZERO)
                     |=> reg_rdata_out[scil_pkg::ST0_TX_EVENT]
                         == (|$past(st_q.tx_src & st_q.tx_src_en))
                     && reg_rdata_out[scil_pkg::ST0_RX_EVENT]
                         == (|$past(st_q.rx_err & st_q.rx_src_en)))
    else $error("event summary does not match sources");

  a_tx_ready_request_full: // RULE_05
    assert property (({1'b0, tx_fill_in} > {1'b0, st_q.threshold}) || !st_q.tx_en
                     |=> !st_q.tx_ready)
    else $error("transmit ready held past threshold or disable");

  a_tx_ready_request_reset: // RULE_06
    assert property (tx_rst_cmd |=> !st_q.tx_ready && tx_reset_out)
    else $error("transmit reset did not clear ready");

  a_rx_ready_request_empty: // RULE_07
    assert property (st_q.rx_ready && rx_cond && !rx_rst_cmd |=> st_q.rx_ready)
    else $error("receive ready dropped before empty");

  a_rx_ready_request_reset: // RULE_08
    assert property (rx_rst_cmd || !rx_cond |=> !st_q.rx_ready)
    else $error("receive ready not cleared");

  a_w1c_tx: // RULE_09
    assert property (wr_tx_src |=> st_q.tx_src
                     == (($past(st_q.tx_src) & ~$past(reg_wdata_in[2:0])) | $past(tx_set)))
    else $error("write-one-to-clear misbehaves");

  a_idle_clear: // RULE_10
    assert property (wr_tx_data && !tx_idle_flag_in |=> !st_q.tx_src[scil_pkg::TXS_IDLE]
                     && tx_push_out)
    else $error("idle source survived a data write");

  a_char_clear: // RULE_11
    assert property (rd_rx_data |=> (st_q.rx_err & scil_pkg::RX_CHAR_ERR_MASK)
                     == ($past(rx_event_in) & scil_pkg::RX_CHAR_ERR_MASK) && rx_pop_out)
    else $error("character errors not cleared by read");

  a_frame_copy: // RULE_12
    assert property (frame_done |=> st_q.frame_status == $past(st_q.rx_err))
    else $error("frame status not loaded at frame end");

  a_err_reset: // RULE_13
    assert property (frame_done |=> st_q.rx_err == $past(rx_event_in))
    else $error("error status not reset at frame end");

  a_rate_reload: // RULE_14
    assert property (st_q.tx_tick |-> st_q.tx_cnt
                     == scil_period($past(st_q.time_const), $past(st_q.tx_exp)) - 24'h000001)
    else $error("bit period reload wrong");

endmodule : scil_top

// >>> verification/scil_chan_model.sv
// Behavioural model of the channel datapath that feeds the interrupt logic.
// Assumes the shared system clock; buffer loads and drains are commanded by the bench.
`timescale 1ns/1ps

module scil_chan_model #(
  parameter int FILL_W = 6
) (
  input  wire logic              mclk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              tx_push_in,
  input  wire logic              tx_reset_in,
  input  wire logic              tx_drain_in,
  input  wire logic              rx_pop_in,
  input  wire logic              rx_reset_in,
  input  wire logic              rx_load_in,
  input  wire logic [FILL_W-1:0] rx_load_n_in,
  output logic      [FILL_W-1:0] tx_fill_out,
  output logic      [FILL_W-1:0] rx_fill_out,
  output logic      [7:0]        rx_data_out,
  output logic                   rx_last_out
);
  logic [7:0] spin_q;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_fill_out <= '0;
      rx_fill_out <= '0;
      spin_q      <= 8'h00;
    end else begin
      spin_q <= spin_q + 8'h01;
      if (tx_reset_in) begin
        tx_fill_out <= '0;
      end else begin
        tx_fill_out <= tx_fill_out + FILL_W'(tx_push_in) - FILL_W'(tx_drain_in);
      end
      if (rx_reset_in) begin
        rx_fill_out <= '0;
      end else if (rx_load_in) begin
        rx_fill_out <= rx_load_n_in;
      end else if (rx_pop_in && rx_fill_out != '0) begin
        rx_fill_out <= rx_fill_out - FILL_W'(1);
      end
    end
  end

  // Empty buffer shows a moving pattern, never a stale character
  assign rx_data_out = (rx_fill_out == '0) ? spin_q : 8'hA0 + 8'(rx_fill_out);
  assign rx_last_out = (rx_fill_out == FILL_W'(1));
endmodule : scil_chan_model

// >>> verification/scil_top_tb.sv
// Self-checking bench of the serial channel interrupt logic.
// Assumes the datapath model beside it; all stimulus is driven at rising edges.
`timescale 1ns/1ps

module scil_top_tb;
  typedef struct packed {logic wr; logic [3:0] addr; logic [7:0] data;} scil_row_t;
  logic       mclk_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, tx_data_out, rd_v;
  logic [5:0] tx_fill, rx_fill, load_n = 6'h00;
  logic [7:0] rx_data;
  logic [4:0] rx_event_in = 5'h00;
  logic       rx_last, underrun_flag_in = 1'b0, tx_idle_flag_in = 1'b0, cts_in = 1'b0;
  logic       tx_push_out, rx_pop_out, tx_reset_out, rx_reset_out, drain = 1'b0, load = 1'b0;
  logic       tx_bit_tick_out, rx_bit_tick_out, irq_out;
  int         n_mismatch = 0, comparisons = 0, cyc = 0, n;
  localparam scil_row_t ROWS[18] = '{
    '{1'b0, scil_pkg::OFF_STATUS_ZERO, 8'h00}, '{1'b0, scil_pkg::OFF_IRQ_ENABLE, 8'h00},
    '{1'b0, scil_pkg::OFF_TIME_CONST, 8'h01}, '{1'b0, scil_pkg::OFF_RATE_EXP, 8'h00},
    '{1'b1, scil_pkg::OFF_IRQ_ENABLE, 8'hC3}, '{1'b0, scil_pkg::OFF_IRQ_ENABLE, 8'hC3},
    '{1'b1, scil_pkg::OFF_TX_SRC_EN, 8'h07}, '{1'b0, scil_pkg::OFF_TX_SRC_EN, 8'h07},
    '{1'b1, scil_pkg::OFF_RX_SRC_EN, 8'h1F}, '{1'b0, scil_pkg::OFF_RX_SRC_EN, 8'h1F},
    '{1'b1, scil_pkg::OFF_TX_THRESHOLD, 8'h03}, '{1'b1, scil_pkg::OFF_TIME_CONST, 8'h03},
    '{1'b1, scil_pkg::OFF_RATE_EXP, 8'h21}, '{1'b0, scil_pkg::OFF_TX_THRESHOLD, 8'h03},
    '{1'b1, scil_pkg::OFF_STATUS_ZERO, 8'hFF}, '{1'b0, scil_pkg::OFF_STATUS_ZERO, 8'h00},
    '{1'b0, 4'hD, 8'h00}, '{1'b1, scil_pkg::OFF_IRQ_ENABLE, 8'h00}};

  scil_top #(.FILL_W(6)) scil_top_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .tx_fill_in(tx_fill),
    .rx_fill_in(rx_fill), .rx_data_in(rx_data), .rx_last_in(rx_last),
    .underrun_flag_in(underrun_flag_in), .tx_idle_flag_in(tx_idle_flag_in),
    .rx_event_in(rx_event_in), .cts_in(cts_in), .tx_push_out(tx_push_out),
    .tx_data_out(tx_data_out), .rx_pop_out(rx_pop_out), .tx_reset_out(tx_reset_out),
    .rx_reset_out(rx_reset_out), .tx_bit_tick_out(tx_bit_tick_out),
    .rx_bit_tick_out(rx_bit_tick_out), .irq_out(irq_out));
  scil_chan_model #(.FILL_W(6)) scil_chan_model_inst (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .tx_push_in(tx_push_out), .tx_reset_in(tx_reset_out),
    .tx_drain_in(drain), .rx_pop_in(rx_pop_out), .rx_reset_in(rx_reset_out),
    .rx_load_in(load), .rx_load_n_in(load_n), .tx_fill_out(tx_fill),
    .rx_fill_out(rx_fill), .rx_data_out(rx_data), .rx_last_out(rx_last));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : check_byte
  task automatic check_bit(input string nm, input logic e, input logic g);
    check_byte(nm, {7'h00, e}, {7'h00, g});
  endtask : check_bit
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask : wait_cyc
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_wr
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 rd_v = reg_rdata_out;
    check_byte(nm, e, rd_v);
  endtask : rd_chk
  task automatic pulse(input logic u, input logic i, input logic [4:0] r);
    @(posedge mclk_in);
    underrun_flag_in <= u;
    tx_idle_flag_in  <= i;
    rx_event_in      <= r;
    @(posedge mclk_in);
    underrun_flag_in <= 1'b0;
    tx_idle_flag_in  <= 1'b0;
    rx_event_in      <= 5'h00;
    wait_cyc(2);
  endtask : pulse
  task automatic mdl(input logic dr, input logic ld, input logic [5:0] k);
    @(posedge mclk_in);
    drain  <= dr;
    load   <= ld;
    load_n <= k;
    @(posedge mclk_in);
    drain <= 1'b0;
    load  <= 1'b0;
  endtask : mdl
  task automatic tick_gap(input bit rx);
    #1;
    for (int i = 0; i < 600 && !(rx ? rx_bit_tick_out : tx_bit_tick_out); i++) wait_cyc(1);
    n = 0;
    do begin
      wait_cyc(1);
      n++;
    end while (!(rx ? rx_bit_tick_out : tx_bit_tick_out) && n < 600);
  endtask : tick_gap

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    foreach (ROWS[r]) begin
      if (ROWS[r].wr) reg_wr(ROWS[r].addr, ROWS[r].data);
      else rd_chk(ROWS[r].addr, ROWS[r].data, "register row");
    end
    tick_gap(1'b0);
    check_byte("tx bit period", 8'd6, 8'(n));
    tick_gap(1'b1);
    check_byte("rx bit period", 8'd12, 8'(n));
    reg_wr(scil_pkg::OFF_CONTROL, 8'h01);
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h01, "tx ready set");
    reg_wr(scil_pkg::OFF_IRQ_ENABLE, 8'h01);
    wait_cyc(3);
    check_bit("irq tx ready", 1'b1, irq_out);
    for (int i = 0; i < 4; i++) begin
      reg_wr(scil_pkg::OFF_TX_DATA, 8'h50 + 8'(i));
      #1 check_byte("tx data", 8'h50 + 8'(i), tx_data_out);
      check_bit("tx push", 1'b1, tx_push_out);
      if (i == 2) rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h01, "ready below");
    end
    wait_cyc(1);
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h00, "ready at fill");
    check_bit("irq off", 1'b0, irq_out);
    repeat (4) mdl(1'b1, 1'b0, 6'h00);
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h01, "ready rearmed");
    reg_wr(scil_pkg::OFF_CONTROL, 8'h05);
    #1 check_bit("tx reset pulse", 1'b1, tx_reset_out);
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h00, "tx reset cmd");
    reg_wr(scil_pkg::OFF_CONTROL, 8'h00);
    reg_wr(scil_pkg::OFF_CONTROL, 8'h01);
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h01, "ready enabled");
    reg_wr(scil_pkg::OFF_CONTROL, 8'h00);
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h00, "tx disabled");
    mdl(1'b0, 1'b1, 6'h02);
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h02, "rx ready set");
    rd_chk(scil_pkg::OFF_RX_DATA, 8'hA2, "rx char one");
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h02, "rx ready kept");
    rd_chk(scil_pkg::OFF_RX_DATA, 8'hA1, "rx char two");
    wait_cyc(1);
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h00, "rx empty");
    mdl(1'b0, 1'b1, 6'h03);
    reg_wr(scil_pkg::OFF_CONTROL, 8'h08);
    #1 check_bit("rx reset pulse", 1'b1, rx_reset_out);
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h00, "rx reset cmd");
    reg_wr(scil_pkg::OFF_IRQ_ENABLE, 8'h00);
    pulse(1'b1, 1'b0, 5'h00);
    rd_chk(scil_pkg::OFF_TX_SRC, 8'h01, "underrun");
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h80, "tx summary");
    check_bit("irq masked", 1'b0, irq_out);
    reg_wr(scil_pkg::OFF_TX_SRC, 8'h00);
    rd_chk(scil_pkg::OFF_TX_SRC, 8'h01, "write zero");
    reg_wr(scil_pkg::OFF_TX_SRC, 8'h01);
    rd_chk(scil_pkg::OFF_TX_SRC, 8'h00, "write one");
    pulse(1'b0, 1'b1, 5'h00);
    rd_chk(scil_pkg::OFF_TX_SRC, 8'h02, "idle");
    reg_wr(scil_pkg::OFF_TX_DATA, 8'h77);
    rd_chk(scil_pkg::OFF_TX_SRC, 8'h00, "idle by data");
    @(posedge mclk_in);
    cts_in <= 1'b1;
    wait_cyc(6);
    rd_chk(scil_pkg::OFF_TX_SRC, 8'h04, "cts change");
    reg_wr(scil_pkg::OFF_TX_SRC_EN, 8'h00);
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h00, "source masked");
    reg_wr(scil_pkg::OFF_TX_SRC_EN, 8'h04);
    reg_wr(scil_pkg::OFF_IRQ_ENABLE, 8'h80);
    wait_cyc(3);
    check_bit("irq tx event", 1'b1, irq_out);
    reg_wr(scil_pkg::OFF_TX_SRC, 8'h04);
    reg_wr(scil_pkg::OFF_IRQ_ENABLE, 8'h40);
    pulse(1'b0, 1'b0, 5'h01);
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h40, "rx summary");
    check_bit("irq rx event", 1'b1, irq_out);
    pulse(1'b0, 1'b0, 5'h06);
    rd_chk(scil_pkg::OFF_RX_ERR, 8'h07, "char errors");
    mdl(1'b0, 1'b1, 6'h01);
    rd_chk(scil_pkg::OFF_RX_DATA, 8'hA1, "err char");
    rd_chk(scil_pkg::OFF_RX_ERR, 8'h00, "errors by read");
    pulse(1'b0, 1'b0, 5'h18);
    mdl(1'b0, 1'b1, 6'h01);
    rd_chk(scil_pkg::OFF_RX_DATA, 8'hA1, "async last");
    rd_chk(scil_pkg::OFF_RX_ERR, 8'h18, "others kept");
    rd_chk(scil_pkg::OFF_FRAME_STATUS, 8'h00, "no copy async");
    reg_wr(scil_pkg::OFF_RX_ERR, 8'h08);
    reg_wr(scil_pkg::OFF_CONTROL, 8'h02);
    pulse(1'b0, 1'b0, 5'h04);
    mdl(1'b0, 1'b1, 6'h01);
    rd_chk(scil_pkg::OFF_RX_DATA, 8'hA1, "frame last");
    rd_chk(scil_pkg::OFF_FRAME_STATUS, 8'h14, "frame copy");
    rd_chk(scil_pkg::OFF_RX_ERR, 8'h00, "frame reset");
    mdl(1'b0, 1'b1, 6'h02);
    reg_wr(scil_pkg::OFF_IRQ_ENABLE, 8'h02);
    wait_cyc(3);
    check_bit("irq rx ready", 1'b1, irq_out);
    @(posedge mclk_in);
    sys_rst_in <= 1'b1;
    wait_cyc(3);
    check_bit("irq in reset", 1'b0, irq_out);
    @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd_chk(scil_pkg::OFF_STATUS_ZERO, 8'h00, "status reset");
    rd_chk(scil_pkg::OFF_IRQ_ENABLE, 8'h00, "enable reset");
    final_report();
  end
endmodule : scil_top_tb
